// ---- azms_host_model.sv ----
/* host model: sends one 32-bit channel word per frame on sck.
   assumes the sequencer samples sdi on rising sck while cs_n is low. */
module azms_host_model
(
  output logic sck,
  output logic cs_n,
  output logic sdi
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    sck = 1'b0;
    cs_n = 1'b1;
    sdi = 1'b0;
  end
  // sck stands still between frames; sdi flips after release so stale data shows
  task automatic frame(input logic [31:0] w);
    cs_n = 1'b0;
    for (int i = 31; i >= 0; i--)
    begin
      sdi = w[i];
      #24 sck = 1'b1;
      #24 sck = 1'b0;
    end
    #24 cs_n = 1'b1;
    sdi = ~sdi;
  endtask
endmodule

// ---- azms_pkg.sv ----
/*
  package for the autozero multiplexer sequencer: link word layout, mux
  selections, edge numbers, timing counts and the state enumeration.
  assumes a 250 mhz system clock and a serial clock from the host.
*/
package azms_pkg;
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned CFG_BITS = 16;
  localparam logic [5:0] MUX_EDGE = 6'h0d;
  localparam logic [5:0] START_EDGE = 6'h20;
  localparam int unsigned SETTLE_US = 50;
  localparam int unsigned SETTLE_CYC = SETTLE_US * CLK_MHZ;
  localparam int unsigned CH_POS_MSB = 15;
  localparam int unsigned CH_NEG_MSB = 13;
  localparam int unsigned MODE_BIT = 11;
  localparam int unsigned OSR_MSB = 10;
  localparam logic [3:0] OSR_MIN = 4'h6;
  localparam logic [3:0] OSR_RESET = 4'h6;
  localparam logic [1:0] CH_RESET_POS = 2'h0;
  localparam logic [1:0] CH_RESET_NEG = 2'h1;

  typedef struct packed {
    logic [1:0] pos;
    logic [1:0] neg;
    logic double_speed_mode;
    logic [3:0] oversample_ratio;
  } azms_cfg_t;

  typedef struct packed {
    logic [1:0] buffer_a_positive_input;
    logic [1:0] buffer_b_positive_input;
  } azms_mux_t;

  typedef enum {AZMS_IDLE, AZMS_HALF1, AZMS_SETTLE, AZMS_HALF2} azms_phase_t;
endpackage

// ---- azms_sequencer.sv ----
/*
  autozero multiplexer sequencer: captures the channel word on the serial
  link clock, switches the mux, times half-conversions on clk.
  assumes the host shifts a word msb first on sck rising edges while cs_n low;
  one modulator cycle is one clk cycle.
*/
// How it works
// [R01] host shifts channel word over serial link
// [R02] edge 13 connects chosen pair to buffers
// [R03] edge 32 starts the conversion
// [R04] single speed swaps polarity at midpoint
// [R05] filter subtracts the two half results
// [R06] end of conversion restores opposite polarity
// [R07] new channel switches at next edge 13
// [R08] double speed reverses right after half one
// [R09] double speed waits settle before half two
// [R10] host picks double speed at low ratios
// [R11] host may drop alternate double speed results
// [R12] half length derives from oversample ratio
module azms_sequencer
  import azms_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic sdi,
  input wire logic signed [23:0] modulator_sum,
  output azms_pkg::azms_mux_t mux_sel,
  output logic half_strobe,
  output logic converting,
  output logic result_valid,
  output logic signed [24:0] result
);
  import azms_pkg::*;

  // link domain: holds the word, counts falling edges, flags edges 13 and 32
  typedef struct packed {
    azms_cfg_t cfg;
    logic mux_tog;
    logic start_tog;
  } azms_link_t;

  azms_link_t lk_reg, lk_next;
  logic [CFG_BITS-1:0] shift_r;
  logic [5:0] edges_reg, edges_next;
  logic [3:0] osr_field;
  logic frame_rst_n;

  // sample on rising edge, act on falling edge as the host expects
  always_ff @(posedge sck or negedge reset_n)
  begin
    if (!reset_n)
      shift_r <= '0;
    else if (!cs_n)
      shift_r <= {shift_r[CFG_BITS-2:0], sdi}; // [R01]
  end

  // sck stands still between frames, so only an asynchronous clear on the
  // idle frame select can restart the count for the next frame
  assign frame_rst_n = reset_n & ~cs_n;

  always_comb
  begin
    // edges past 32 are ignored until the frame ends
    if (edges_reg != START_EDGE)
      edges_next = edges_reg + 6'h01;
    else
      edges_next = edges_reg;
  end

  always_ff @(negedge sck or negedge frame_rst_n)
  begin
    if (!frame_rst_n)
      edges_reg <= '0;
    else
      edges_reg <= edges_next;
  end

  assign osr_field = shift_r[OSR_MSB-3 -: 4];

  always_comb
  begin
    lk_next = lk_reg;
    if (!cs_n && edges_next == MUX_EDGE)
    begin
      // upper bits of the word are in by edge 13
      lk_next.cfg.pos = shift_r[CH_POS_MSB-3 -: 2];
      lk_next.cfg.neg = shift_r[CH_NEG_MSB-3 -: 2];
      lk_next.cfg.double_speed_mode = shift_r[MODE_BIT-3];
      // a shorter half would let the two half strobes run together
      if (osr_field < OSR_MIN)
        lk_next.cfg.oversample_ratio = OSR_MIN; // [R12]
      else
        lk_next.cfg.oversample_ratio = osr_field; // [R12]
      lk_next.mux_tog = ~lk_reg.mux_tog; // [R02] [R07]
    end
    if (!cs_n && edges_next == START_EDGE && edges_reg != START_EDGE)
      lk_next.start_tog = ~lk_reg.start_tog; // [R03]
  end

  always_ff @(negedge sck or negedge reset_n)
  begin
    if (!reset_n)
      lk_reg <= '{cfg: '{CH_RESET_POS, CH_RESET_NEG, 1'b0, OSR_RESET},
                  mux_tog: 1'b0,
                  start_tog: 1'b0};
    else
      lk_reg <= lk_next;
  end

  // system domain
  typedef struct packed {
    logic [2:0] mux_sync;
    logic [2:0] start_sync;
    azms_cfg_t cfg;
    logic swapped;
    azms_mux_t mux;
    azms_phase_t phase;
    logic [15:0] count;
    logic [15:0] settle;
    logic signed [23:0] first;
    logic signed [24:0] result;
    logic valid;
    logic half;
    logic busy;
  } azms_core_t;

  azms_core_t c_reg, c_next;
  logic mux_evt, start_evt;
  logic [15:0] half_len;

  assign mux_evt = c_reg.mux_sync[2] ^ c_reg.mux_sync[1];
  assign start_evt = c_reg.start_sync[2] ^ c_reg.start_sync[1];
  // half length grows with the ratio; cfg is stable (frozen) after edge 13
  assign half_len = 16'h0001 << c_reg.cfg.oversample_ratio; // [R12]

  always_comb
  begin
    c_next = c_reg;
    c_next.mux_sync = {c_reg.mux_sync[1:0], lk_reg.mux_tog};
    c_next.start_sync = {c_reg.start_sync[1:0], lk_reg.start_tog};
    c_next.valid = 1'b0;
    c_next.half = 1'b0;
    if (mux_evt)
    begin
      // cfg bits changed on the same link edge as mux_tog, and have settled by the time the toggle passes the sync flops
      c_next.cfg = lk_reg.cfg;
      c_next.swapped = 1'b0; // [R02] [R07]
    end
    case (c_reg.phase)
      AZMS_IDLE:
      begin
        if (start_evt)
        begin
          c_next.phase = AZMS_HALF1; // [R03]
          c_next.count = '0;
        end
      end
      AZMS_HALF1:
      begin
        c_next.count = c_reg.count + 16'h0001;
        if (c_reg.count == half_len - 16'h0001)
        begin
          c_next.first = modulator_sum;
          c_next.half = 1'b1;
          c_next.swapped = ~c_reg.swapped; // [R04] [R08]
          c_next.count = '0;
          c_next.settle = '0;
          c_next.phase = c_reg.cfg.double_speed_mode ? AZMS_SETTLE : AZMS_HALF2;
        end
      end
      AZMS_SETTLE:
      begin
        c_next.settle = c_reg.settle + 16'h0001;
        if (c_reg.settle == 16'(SETTLE_CYC - 1))
          c_next.phase = AZMS_HALF2; // [R09]
      end
      AZMS_HALF2:
      begin
        c_next.count = c_reg.count + 16'h0001;
        if (c_reg.count == half_len - 16'h0001)
        begin
          // polarity reversal makes the difference cancel offset
          c_next.result = 25'(c_reg.first) - 25'(modulator_sum); // [R05]
          c_next.valid = 1'b1;
          c_next.half = 1'b1;
          c_next.swapped = ~c_reg.swapped; // [R06]
          c_next.phase = AZMS_IDLE;
        end
      end
      default:
        c_next.phase = AZMS_IDLE;
    endcase
    // converting leaves a flop like every other output
    c_next.busy = (c_next.phase != AZMS_IDLE);
    if (c_next.swapped)
      c_next.mux = '{c_next.cfg.neg, c_next.cfg.pos};
    else
      c_next.mux = '{c_next.cfg.pos, c_next.cfg.neg};
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      c_reg <= '{mux_sync: '0,
                 start_sync: '0,
                 cfg: '{CH_RESET_POS, CH_RESET_NEG, 1'b0, OSR_RESET},
                 swapped: 1'b0,
                 mux: '{CH_RESET_POS, CH_RESET_NEG},
                 phase: AZMS_IDLE,
                 count: '0,
                 settle: '0,
                 first: '0,
                 result: '0,
                 valid: 1'b0,
                 half: 1'b0,
                 busy: 1'b0};
    else
      c_reg <= c_next;
  end

  assign mux_sel = c_reg.mux;
  assign half_strobe = c_reg.half;
  assign converting = c_reg.busy;
  assign result_valid = c_reg.valid;
  assign result = c_reg.result;
endmodule

// ---- azms_sequencer_chk.sv ----
/* checker for the autozero sequencer: strobe, result and mux relations.
   assumes the sequencer ports and package; bound after the module. */
module azms_sequencer_chk
  import azms_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic sdi,
  input wire logic signed [23:0] modulator_sum,
  input azms_pkg::azms_mux_t mux_sel,
  input wire logic half_strobe,
  input wire logic converting,
  input wire logic result_valid,
  input wire logic signed [24:0] result
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  azms_mux_t start_reg;
  logic conv_reg;
  // pair seen at start; later swaps are judged against it
  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n)
      {start_reg, conv_reg} <= '0;
    else
    begin
      conv_reg <= converting;
      if (converting && !conv_reg)
        start_reg <= mux_sel;
    end
  strobe_live_a: assert property (half_strobe |-> converting != result_valid)
    else $error("strobe outside conversion");
  last_half_a: assert property (result_valid |-> half_strobe) else $error("result without half end");
  conv_end_a: assert property (result_valid |=> !converting) else $error("conversion runs on");
  strobe_once_a: assert property (half_strobe |=> !half_strobe) else $error("strobe too long");
  result_hold_a: assert property ($changed(result) |-> result_valid) else $error("result moved");
  mid_swap_a: assert property (half_strobe && !result_valid |-> mux_sel == {start_reg[1:0], start_reg[3:2]})
    else $error("no swap at midpoint");
  end_restore_a: assert property (result_valid |-> mux_sel == start_reg) else $error("pair not restored");
  quiet_mux_a: assert property (converting && !half_strobe |-> $stable(mux_sel)) else $error("mux moved");
  cover property ($rose(converting));
  cover property (half_strobe && !result_valid);
  cover property (result_valid);
endmodule
bind azms_sequencer azms_sequencer_chk u_azms_sequencer_chk(.clk(clk), .reset_n(reset_n), .sck(sck), .cs_n(cs_n),
  .sdi(sdi), .modulator_sum(modulator_sum), .mux_sel(mux_sel), .half_strobe(half_strobe), .converting(converting),
  .result_valid(result_valid), .result(result));

// ---- tb.sv ----
/* testbench for the autozero sequencer: frames from the host model.
   assumes the hand-over timing of the sequencer. */
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import azms_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic sck, cs_n, sdi, half_strobe, converting, result_valid;
  logic signed [23:0] modulator_sum = 24'sh0;
  logic signed [24:0] result;
  azms_mux_t mux_sel;
  int n_mismatch = 0;
  int compares = 0;
  int cyc = 0;
  always #2 clk = ~clk;
  azms_sequencer u_azms_sequencer(.clk(clk), .reset_n(reset_n), .sck(sck), .cs_n(cs_n), .sdi(sdi),
    .modulator_sum(modulator_sum), .mux_sel(mux_sel), .half_strobe(half_strobe), .converting(converting),
    .result_valid(result_valid), .result(result));
  azms_host_model u_azms_host_model(.sck(sck), .cs_n(cs_n), .sdi(sdi));
  task automatic print_verdict();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic cmp(input string what, input logic [24:0] exp, input logic [24:0] got);
    compares++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one frame then a full conversion; the second half sees a different sum
  task automatic conv(input logic [1:0] p, input logic [1:0] n, input logic d);
    int t1;
    modulator_sum = 24'sh0003e8;
    fork
      u_azms_host_model.frame({p, n, d, 4'h6, 23'h0});
    join_none
    #644;
    cmp("mux at edge 13", 25'({p, n}), 25'(mux_sel));
    cmp("idle before edge 32", 25'(0), 25'(converting));
    #912;
    cmp("started", 25'(1), 25'(converting));
    wait (half_strobe);
    #1;
    t1 = cyc;
    cmp("mid swap", 25'({n, p}), 25'(mux_sel));
    #8 modulator_sum = -24'sh000064;
    wait (result_valid);
    #1;
    cmp("half gap", 25'(64 + d * SETTLE_CYC), 25'(cyc - t1));
    cmp("difference", 25'(1100), result);
    cmp("restored", 25'({p, n}), 25'(mux_sel));
    @(posedge clk);
    #1;
  endtask
  // pair 2/3 in single speed straight after reset
  task automatic run_single();
    conv(2'h2, 2'h3, 1'b0);
  endtask
  // same pair in double speed; the host keeps this one result of the pair
  task automatic run_double();
    conv(2'h2, 2'h3, 1'b1);
  endtask
  // pair 1/0 in single speed: the mux must follow the new word
  task automatic run_switch();
    conv(2'h1, 2'h0, 1'b0);
  endtask
  // ceiling well above three frames plus one settle wait
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_mismatch++;
      print_verdict();
    end
  end
  initial
  begin
    #7 reset_n = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    cmp("reset pair", 25'({CH_RESET_POS, CH_RESET_NEG}), 25'(mux_sel));
    run_single();
    run_double();
    run_switch();
    print_verdict();
  end
endmodule
